// >>> hw/mod_pll_regs_consts.vh
`ifndef MOD_PLL_REGS_CONSTS_VH
`define MOD_PLL_REGS_CONSTS_VH

// register addresses
`define ADDR_W              5
`define ADDR_STATUS         5'h00
`define ADDR_MIXER_CONTROL  5'h03
`define ADDR_LOOP_SYNTH     5'h04
`define ADDR_CLOCK_SYNC     5'h05
`define ADDR_REVISION       5'h0D

// reset values
`define RST_MIXER_CONTROL   8'h00
`define RST_LOOP_SYNTH      8'h00
`define RST_CLOCK_SYNC      8'h00
`define RST_RDATA           8'h00

// revision value, arbitrary
`define REVISION_VALUE      4'h1

// mixer_control fields
`define MIX_CHANNEL_BIT     7
`define MIX_HILBERT_BIT     6
`define MIX_DUAL_BIT        5
`define MIX_SIDEBAND_BIT    4
`define MIX_RATE_HI         3
`define MIX_RATE_LO         2

// loop_synth_config fields
`define LOOP_ENABLE_BIT     7
`define LOOP_MULT_HI        6
`define LOOP_MULT_LO        5
`define LOOP_DIV_HI         4
`define LOOP_DIV_LO         3
`define LOOP_BW_HI          2
`define LOOP_BW_LO          1
`define LOOP_LOCKPIN_BIT    0

// clock_sync_adjust fields
`define SYNC_OFFSET_HI      7
`define SYNC_OFFSET_LO      4
`define SYNC_MODE_BIT       3
`define SYNC_PHASE_HI       2
`define SYNC_PHASE_LO       0

// status register
`define STATUS_LOCK_BIT     1

// mixer rate codes
`define RATE_NONE           2'h0
`define RATE_HALF           2'h1
`define RATE_QUARTER        2'h2
`define RATE_EIGHTH         2'h3

// phase index steps per sample (eight steps per turn)
`define STEP_HALF           3'h4
`define STEP_QUARTER        3'h2
`define STEP_EIGHTH         3'h1

// coefficients, scaled by 256
`define COEF_W              10
`define COEF_SHIFT          8
`define COEF_ONE            10'h100
`define COEF_RT2            10'h0B5
`define COEF_ZERO           10'h000
`define QUARTER_TURN        3'h2

// datapath
`define DATA_W              14
`define PROD_W              25
`define DCLK_TAPS           16
`define DCLK_TAP_W          4

`endif

// >>> hw/mixer_coef_gen.v
`timescale 1ns/1ns
`include "mod_pll_regs_consts.vh"

module mixer_coef_gen (
    // clock and reset
    input  wire                        i_core_clk,
    input  wire                        i_rst_n,
    // settings
    input  wire [1:0]                  i_rate,
    input  wire [2:0]                  i_offset,
    // events
    input  wire                        i_advance,
    input  wire                        i_resync,
    // coefficients
    output reg  signed [`COEF_W-1:0]   o_cos,
    output reg  signed [`COEF_W-1:0]   o_sin
);

    function [`COEF_W-1:0] cos_lut;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: cos_lut = `COEF_ONE;
                3'h1: cos_lut = `COEF_RT2;
                3'h2: cos_lut = `COEF_ZERO;
                3'h3: cos_lut = -`COEF_RT2;
                3'h4: cos_lut = -`COEF_ONE;
                3'h5: cos_lut = -`COEF_RT2;
                3'h6: cos_lut = `COEF_ZERO;
                default: cos_lut = `COEF_RT2;
            endcase
        end
    endfunction

    reg  [2:0] n_q;
    reg  [2:0] n_d;
    reg  [2:0] step;
    wire [5:0] prod;
    wire [2:0] idx;

    always @* begin
        case (i_rate)
            `RATE_HALF:    step = `STEP_HALF;
            `RATE_QUARTER: step = `STEP_QUARTER;
            `RATE_EIGHTH:  step = `STEP_EIGHTH;
            default:       step = 3'h0;
        endcase
        n_d = n_q;
        if (i_resync) begin
            n_d = 3'h0;
        end else if (i_advance) begin
            n_d = n_q + 3'h1;
        end
    end

    // offset moves the start of the sequence, scaled to the rate
    assign prod = (n_d + i_offset) * step;
    assign idx  = prod[2:0];

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            n_q   <= 3'h0;
            o_cos <= `COEF_ONE;
            o_sin <= `COEF_ZERO;
        end else begin
            n_q <= n_d;
            if (i_rate == `RATE_NONE) begin
                o_cos <= `COEF_ONE;
                o_sin <= `COEF_ZERO;
            end else begin
                o_cos <= cos_lut(idx);
                o_sin <= cos_lut(idx - `QUARTER_TURN);
            end
        end
    end

endmodule

// >>> hw/mod_pll_sync_regs.v
`timescale 1ns/1ns
`include "mod_pll_regs_consts.vh"

module mod_pll_sync_regs (
    // clock and reset
    input  wire                      i_core_clk,
    input  wire                      i_rst_n,
    // register port
    input  wire                      i_reg_wr,
    input  wire                      i_reg_rd,
    input  wire [`ADDR_W-1:0]        i_reg_addr,
    input  wire [7:0]                i_reg_wdata,
    output reg  [7:0]                o_reg_rdata,
    // sample data
    input  wire                      i_sample_valid,
    input  wire signed [`DATA_W-1:0] i_i_data,
    input  wire signed [`DATA_W-1:0] i_q_data,
    output reg  signed [`DATA_W-1:0] o_dac_data,
    // loop synthesiser
    input  wire                      i_lock_indicator,
    output reg                       o_loop_enable,
    output reg  [1:0]                o_loop_multiply_select,
    output reg  [1:0]                o_loop_divide_select,
    output reg  [1:0]                o_loop_settle_bw_select,
    // clocks for synchronisation
    input  wire                      i_data_clock_gen,
    input  wire                      i_data_clock_out_mode,
    input  wire                      i_state_clock,
    // shared data clock / lock pin
    input  wire                      i_data_clock_pin,
    output reg                       o_data_clock_pin,
    output reg                       o_data_clock_pin_oe,
    output reg                       o_data_clock_adj
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [7:0] mixer_control_q;
    reg  [7:0] loop_synth_q;
    reg  [7:0] clock_sync_q;

    function [7:0] read_mux;
        input [`ADDR_W-1:0] addr;
        input [7:0]         mix;
        input [7:0]         loop;
        input [7:0]         sync;
        input               locked;
        begin
            read_mux = 8'h00;
            case (addr)
                `ADDR_STATUS:        read_mux[`STATUS_LOCK_BIT] = locked;
                `ADDR_MIXER_CONTROL: read_mux = mix;
                `ADDR_LOOP_SYNTH:    read_mux = loop;
                `ADDR_CLOCK_SYNC:    read_mux = sync;
                `ADDR_REVISION:      read_mux = {4'h0, `REVISION_VALUE};
                default:             read_mux = 8'h00;
            endcase
        end
    endfunction

    wire       loop_on    = loop_synth_q[`LOOP_ENABLE_BIT];
    wire       lock_pin   = loop_synth_q[`LOOP_LOCKPIN_BIT];
    wire       locked_now = loop_on & i_lock_indicator;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mixer_control_q <= `RST_MIXER_CONTROL;
            loop_synth_q    <= `RST_LOOP_SYNTH;
            clock_sync_q    <= `RST_CLOCK_SYNC;
            o_reg_rdata     <= `RST_RDATA;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `ADDR_MIXER_CONTROL: mixer_control_q <= i_reg_wdata;
                    `ADDR_LOOP_SYNTH:    loop_synth_q    <= i_reg_wdata;
                    `ADDR_CLOCK_SYNC:    clock_sync_q    <= i_reg_wdata;
                    default:             mixer_control_q <= mixer_control_q;
                endcase
            end
            if (i_reg_rd) begin
                o_reg_rdata <= read_mux(i_reg_addr, mixer_control_q, loop_synth_q, clock_sync_q, locked_now);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loop synthesiser settings, passed to the analog loop
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_loop_enable           <= 1'b0;
            o_loop_multiply_select  <= 2'h0;
            o_loop_divide_select    <= 2'h0;
            o_loop_settle_bw_select <= 2'h0;
        end else begin
            o_loop_enable           <= loop_on;
            o_loop_multiply_select  <= loop_synth_q[`LOOP_MULT_HI:`LOOP_MULT_LO];
            o_loop_divide_select    <= loop_synth_q[`LOOP_DIV_HI:`LOOP_DIV_LO];
            o_loop_settle_bw_select <= loop_synth_q[`LOOP_BW_HI:`LOOP_BW_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data clock offset line and shared pin
    reg  [`DCLK_TAPS-1:0] dclk_line_q;
    reg                   sync_prev_q;
    wire                  lock_on_pin = loop_on & lock_pin;
    wire                  drive_dclk  = ~lock_on_pin & i_data_clock_out_mode;
    wire                  dclk_src    = drive_dclk ? i_data_clock_gen : i_data_clock_pin;
    wire [3:0]            offset      = clock_sync_q[`SYNC_OFFSET_HI:`SYNC_OFFSET_LO];
    // flipping the sign bit maps -8..+7 onto taps 0..15
    wire [`DCLK_TAP_W-1:0] tap        = {~offset[3], offset[2:0]};
    wire                  dclk_adj    = dclk_line_q[tap];
    wire                  sync_src    = clock_sync_q[`SYNC_MODE_BIT] ? i_state_clock : dclk_adj;
    // the lock-pin select bit alone blocks resync, even with the loop off, so the phase free-runs
    wire                  sync_edge   = ~lock_pin & sync_src & ~sync_prev_q;

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dclk_line_q         <= {`DCLK_TAPS{1'b0}};
            sync_prev_q         <= 1'b0;
            o_data_clock_pin    <= 1'b0;
            o_data_clock_pin_oe <= 1'b0;
            o_data_clock_adj    <= 1'b0;
        end else begin
            dclk_line_q      <= {dclk_line_q[`DCLK_TAPS-2:0], dclk_src};
            sync_prev_q      <= sync_src;
            o_data_clock_adj <= dclk_adj;
            if (lock_on_pin) begin
                o_data_clock_pin    <= i_lock_indicator;
                o_data_clock_pin_oe <= 1'b1;
            end else begin
                o_data_clock_pin    <= dclk_adj;
                o_data_clock_pin_oe <= i_data_clock_out_mode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modulator
    wire signed [`COEF_W-1:0] cos_c;
    wire signed [`COEF_W-1:0] sin_c;

    mixer_coef_gen u_coef (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_rate     (mixer_control_q[`MIX_RATE_HI:`MIX_RATE_LO]),
        .i_offset   (clock_sync_q[`SYNC_PHASE_HI:`SYNC_PHASE_LO]),
        .i_advance  (i_sample_valid),
        .i_resync   (sync_edge),
        .o_cos      (cos_c),
        .o_sin      (sin_c)
    );

    function signed [`DATA_W-1:0] sat;
        input signed [`PROD_W-1:0] v;
        reg   signed [`PROD_W-1:0] s;
        begin
            s = v >>> `COEF_SHIFT;
            if (s > $signed({{(`PROD_W-`DATA_W+1){1'b0}}, {(`DATA_W-1){1'b1}}}))
                sat = {1'b0, {(`DATA_W-1){1'b1}}};
            else if (s < $signed({{(`PROD_W-`DATA_W+1){1'b1}}, {(`DATA_W-1){1'b0}}}))
                sat = {1'b1, {(`DATA_W-1){1'b0}}};
            else
                sat = s[`DATA_W-1:0];
        end
    endfunction

    reg signed [`DATA_W-1:0] i_d1_q;
    reg signed [`DATA_W-1:0] q_d1_q;
    reg signed [`DATA_W-1:0] q_d2_q;

    wire dual     = mixer_control_q[`MIX_DUAL_BIT];
    wire channel  = mixer_control_q[`MIX_CHANNEL_BIT];
    wire hilbert  = dual & mixer_control_q[`MIX_HILBERT_BIT];
    wire sideband = mixer_control_q[`MIX_SIDEBAND_BIT];

    // three-tap quadrature approximation; cheap, narrowband only
    wire signed [`DATA_W:0]   q_hil  = ($signed({i_q_data[`DATA_W-1], i_q_data}) -
                                        $signed({q_d2_q[`DATA_W-1], q_d2_q})) >>> 1;
    wire signed [`DATA_W-1:0] i_path = hilbert ? i_d1_q : i_i_data;
    wire signed [`DATA_W-1:0] q_path = hilbert ? q_hil[`DATA_W-1:0] : i_q_data;
    wire signed [`COEF_W-1:0] sin_s  = sideband ? -sin_c : sin_c;

    wire signed [`PROD_W-1:0] ic = i_path * cos_c;
    wire signed [`PROD_W-1:0] qc = q_path * cos_c;
    wire signed [`PROD_W-1:0] is = i_path * sin_s;
    wire signed [`PROD_W-1:0] qs = q_path * sin_s;

    reg signed [`PROD_W-1:0] sel;
    always @* begin
        case ({dual, channel})
            2'b00:   sel = ic;
            2'b01:   sel = qc;
            2'b10:   sel = ic - qs;
            default: sel = is + qc;
        endcase
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            i_d1_q     <= {`DATA_W{1'b0}};
            q_d1_q     <= {`DATA_W{1'b0}};
            q_d2_q     <= {`DATA_W{1'b0}};
            o_dac_data <= {`DATA_W{1'b0}};
        end else if (i_sample_valid) begin
            i_d1_q     <= i_i_data;
            q_d1_q     <= i_q_data;
            q_d2_q     <= q_d1_q;
            o_dac_data <= sat(sel);
        end
    end

endmodule

// >>> testbench/mod_pll_sync_regs_assertions.sv
`timescale 1ns/1ns
`include "mod_pll_regs_consts.vh"

module mod_pll_sync_regs_checker (
    input wire                      i_core_clk,
    input wire                      i_rst_n,
    input wire                      i_reg_wr,
    input wire                      i_reg_rd,
    input wire [`ADDR_W-1:0]        i_reg_addr,
    input wire [7:0]                i_reg_wdata,
    input wire [7:0]                o_reg_rdata,
    input wire                      i_sample_valid,
    input wire signed [`DATA_W-1:0] o_dac_data,
    input wire                      i_lock_indicator,
    input wire                      o_loop_enable,
    input wire [1:0]                o_loop_multiply_select,
    input wire [1:0]                o_loop_divide_select,
    input wire [1:0]                o_loop_settle_bw_select
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire lwr = i_reg_wr && i_reg_addr == `ADDR_LOOP_SYNTH;
    wire unm = !(i_reg_addr inside {5'h00, 5'h03, 5'h04, 5'h05, 5'h0D});
    ////////////////////////////////////////////////////////////////
    a_enable_copy: assert property (lwr |-> ##2 o_loop_enable == $past(i_reg_wdata[7], 2))
        else $error("loop enable copy wrong");
    a_mult_copy: assert property (lwr |-> ##2 o_loop_multiply_select == $past(i_reg_wdata[6:5], 2))
        else $error("multiply copy wrong");
    a_div_copy: assert property (lwr |-> ##2 o_loop_divide_select == $past(i_reg_wdata[4:3], 2))
        else $error("divide copy wrong");
    a_bw_copy: assert property (lwr |-> ##2 o_loop_settle_bw_select == $past(i_reg_wdata[2:1], 2))
        else $error("settle bandwidth copy wrong");
    a_unmapped_zero: assert property (i_reg_rd && unm |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_lock: assert property (i_reg_rd && i_reg_addr == `ADDR_STATUS && !$past(i_reg_wr)
        |=> o_reg_rdata == {6'h00, $past(o_loop_enable && i_lock_indicator), 1'b0})
        else $error("lock status wrong");
    a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    a_dac_hold: assert property (!i_sample_valid |=> $stable(o_dac_data))
        else $error("converter word moved without sample");
endmodule

bind mod_pll_sync_regs mod_pll_sync_regs_checker chk_u (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_sample_valid(i_sample_valid), .o_dac_data(o_dac_data), .i_lock_indicator(i_lock_indicator),
    .o_loop_enable(o_loop_enable), .o_loop_multiply_select(o_loop_multiply_select),
    .o_loop_divide_select(o_loop_divide_select), .o_loop_settle_bw_select(o_loop_settle_bw_select));

// >>> testbench/mod_pll_sync_regs_test.sv
`timescale 1ns/1ns
`include "mod_pll_regs_consts.vh"

`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
    n_mismatch = n_mismatch + 1; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module mod_pll_sync_regs_test;
    logic clk, rst_n, wr, rd, sv, lock, omode, pin, oe, adj, len, st, gen, pin_in;
    logic [4:0] addr;
    logic [7:0] wd, rdat;
    logic [1:0] mul, dv, bw;
    logic signed [13:0] id, qd, dac, x, y;
    int n_mismatch, num_checks;

    mod_pll_sync_regs dut_u (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_sample_valid(sv), .i_i_data(id), .i_q_data(qd),
        .o_dac_data(dac), .i_lock_indicator(lock), .o_loop_enable(len), .o_loop_multiply_select(mul),
        .o_loop_divide_select(dv), .o_loop_settle_bw_select(bw), .i_data_clock_gen(gen),
        .i_data_clock_out_mode(omode), .i_state_clock(st), .i_data_clock_pin(pin_in),
        .o_data_clock_pin(pin), .o_data_clock_pin_oe(oe), .o_data_clock_adj(adj));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // every drive lands 5 ns after the edge to stay clear of sampling
    task tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task wreg(input [4:0] a, input [7:0] d);
        wr = 1'b1; addr = a; wd = d;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task rreg(input [4:0] a, input [7:0] e);
        rd = 1'b1; addr = a;
        tick(1);
        rd = 1'b0;
        `CHK(rdat, e)
        tick(1);
    endtask
    // strobe lowered with a spare edge so back-to-back calls never retoggle it
    task samp(input int n);
        sv = 1'b1;
        tick(n);
        sv = 1'b0;
        tick(1);
    endtask
    task resync;
        st = 1'b1;
        tick(1);
        st = 1'b0;
    endtask
    function automatic logic signed [13:0] coef(input int p);
        case (p % 8)
            0:       coef = 14'sh0100;
            1, 7:    coef = 14'sh00B5;
            3, 5:    coef = -14'sh00B5;
            4:       coef = -14'sh0100;
            default: coef = 14'sh0000;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    task t_defaults;
        rreg(5'h03, 8'h00);
        rreg(5'h04, 8'h00);
        rreg(5'h05, 8'h00);
        rreg(5'h00, 8'h00);
        rreg(5'h0D, 8'h01);
        wreg(5'h0D, 8'hFF);
        rreg(5'h0D, 8'h01);
        wreg(5'h06, 8'hFF);
        rreg(5'h06, 8'h00);
        rreg(5'h1F, 8'h00);
        wreg(5'h05, 8'h8B);
        rreg(5'h05, 8'h8B);
    endtask
    task t_loop;
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = i;
            wreg(5'h04, {1'b1, k, ~k, k, 1'b0});
            `CHK({len, mul, dv, bw}, {1'b1, k, ~k, k})
            `CHK(bw, k)
            rreg(5'h04, {1'b1, k, ~k, k, 1'b0});
        end
    endtask
    task t_status;
        wreg(5'h04, 8'h80);
        lock = 1'b1;
        rreg(5'h00, 8'h02);
        lock = 1'b0;
        rreg(5'h00, 8'h00);
        wreg(5'h04, 8'h00);
        lock = 1'b1;
        rreg(5'h00, 8'h00);
    endtask
    task t_pin;
        wreg(5'h04, 8'h81);
        tick(2);
        `CHK({oe, pin}, 2'b11)
        lock = 1'b0;
        tick(2);
        `CHK({oe, pin}, 2'b10)
        wreg(5'h04, 8'h00);
        omode = 1'b1;
        tick(2);
        `CHK(oe, 1'b1)
        omode = 1'b0;
        tick(2);
        `CHK(oe, 1'b0)
        lock = 1'b1;
        wreg(5'h04, 8'h01);
        tick(2);
        `CHK({oe, pin}, 2'b00)
        wreg(5'h04, 8'h00);
    endtask
    task dclk_delay(input logic [3:0] o, input logic m, output int d);
        omode = m;
        wreg(5'h05, {o, 4'h0});
        if (m) gen = 1'b1;
        else pin_in = 1'b1;
        d = 0;
        while (adj !== 1'b1 && d < 40) begin
            tick(1);
            d = d + 1;
        end
        `CHK({oe, pin}, {m, 1'b1})
        gen = 1'b0;
        pin_in = 1'b0;
        tick(20);
    endtask
    // only differences count: the fixed pipeline depth is not a rule
    task t_dclk;
        int d0, d1;
        dclk_delay(4'h0, 1'b0, d0);
        dclk_delay(4'h7, 1'b0, d1);
        `CHK(d1 - d0, 7)
        dclk_delay(4'h8, 1'b1, d1);
        `CHK(d1 - d0, -8)
        dclk_delay(4'hD, 1'b0, d1);
        `CHK(d1 - d0, -3)
    endtask
    task t_sync;
        id = 14'sh0100; qd = 14'sh0000;
        wreg(5'h03, {4'h0, `RATE_EIGHTH, 2'b00});
        wreg(5'h05, 8'h08);
        resync();
        samp(1);
        `CHK(dac, coef(0))
        wreg(5'h05, 8'h00);
        resync();
        samp(1);
        `CHK(dac, coef(1))
        pin_in = 1'b1;
        tick(1);
        pin_in = 1'b0;
        tick(20);
        samp(1);
        `CHK(dac, coef(0))
        wreg(5'h04, 8'h01);
        pin_in = 1'b1;
        tick(1);
        pin_in = 1'b0;
        tick(20);
        samp(1);
        `CHK(dac, coef(1))
        wreg(5'h04, 8'h00);
    endtask
    task t_phase;
        logic [1:0] rt;
        logic [2:0] ph;
        id = 14'sh0100;
        for (int r = 1; r < 4; r++) begin
            for (int k = 0; k < 8; k++) begin
                rt = r;
                ph = k;
                wreg(5'h03, {4'h0, rt, 2'b00});
                wreg(5'h05, {4'h0, 1'b1, ph});
                resync();
                samp(1);
                `CHK(dac, coef(k << (3 - r)))
                samp(1);
                `CHK(dac, coef((k + 1) << (3 - r)))
            end
        end
    endtask
    task t_dual;
        logic [1:0] m;
        id = 14'sh0064; qd = -14'sh00C8;
        wreg(5'h05, 8'h08);
        for (int i = 0; i < 4; i++) begin
            m = i;
            wreg(5'h03, {m[1], 2'b01, m[0], `RATE_QUARTER, 2'b00});
            resync();
            samp(1);
            `CHK(dac, m[1] ? qd : id)
            x = m[1] ? id : -qd;
            y = m[0] ? -x : x;
            samp(1);
            `CHK(dac, y)
        end
    endtask
    task t_hilbert;
        id = 14'sh0032;
        wreg(5'h03, 8'h60);
        samp(1);
        id = 14'sh0046;
        samp(1);
        `CHK(dac, 14'sh0032)
        wreg(5'h03, 8'h40);
        samp(1);
        `CHK(dac, 14'sh0046)
        wreg(5'h03, 8'hE0);
        qd = 14'sh0064;
        samp(1);
        qd = 14'sh0028;
        samp(1);
        qd = 14'sh012C;
        samp(1);
        `CHK(dac, 14'sh0064)
    endtask
    task t_reset;
        wreg(5'h04, 8'hFF);
        wreg(5'h03, 8'hFF);
        rst_n = 1'b0;
        tick(2);
        `CHK({len, mul, dv, bw, oe}, 8'h00)
        rst_n = 1'b1;
        tick(1);
        rreg(5'h03, 8'h00);
        rreg(5'h04, 8'h00);
        rreg(5'h05, 8'h00);
    endtask
    // fixed data makes any sample delay in the path harmless
    task t_route;
        logic [1:0] m;
        id = 14'sd100; qd = -14'sd200;
        for (int i = 0; i < 4; i++) begin
            m = i;
            wreg(5'h03, {m[1], ~m[0], m[0], 5'h00});
            tick(3);
            sv = 1'b1;
            tick(3);
            sv = 1'b0;
            `CHK(dac, m[1] ? qd : id)
        end
    endtask
    task t_half;
        id = 14'sd300;
        wreg(5'h03, 8'h04);
        sv = 1'b1;
        tick(3);
        x = dac;
        tick(1);
        y = dac;
        sv = 1'b0;
        `CHK(y, -x)
        `CHK((x < 0) ? -x : x, id)
        wreg(5'h03, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        final_report();
    end

    initial begin
        n_mismatch = 0; num_checks = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; sv = 1'b0; lock = 1'b0; omode = 1'b0;
        addr = 5'h00; wd = 8'h00; id = 14'sd0; qd = 14'sd0;
        st = 1'b0; gen = 1'b0; pin_in = 1'b0;
        tick(6);
        rst_n = 1'b1;
        tick(1);
        t_defaults();
        t_loop();
        t_status();
        t_pin();
        t_route();
        t_half();
        t_dclk();
        t_sync();
        t_phase();
        t_dual();
        t_hilbert();
        t_reset();
        final_report();
    end
endmodule
